// file: ser_status_event.sv
/*
  status event reporting: two filtered event groups, standard event
  latch and status byte with service request.
  assumes same-clock command port and pulses; condition inputs
  come from other domains and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ser_status_event_regs.svh"

// Functional notes
// R1: condition registers mirror inputs, read-only
// R2: rising filter gates 0-to-1 events
// R3: falling filter gates 1-to-0 events
// R4: event bits stay set until read
// R5: event read returns then clears all
// R6: enable mask gates events into summary
// R7: normal summary drives status bit 7
// R8: abnormal summary drives status bit 3
// R9: normal bit 0 calibration, bit 5 trigger wait
// R10: normal bits 8, 9 voltage regulation
// R11: normal bits 10, 12 current regulation
// R12: abnormal bits 0, 1, 4 protection trips
// R13: abnormal bit 3 panel key, 5 sense
// R14: abnormal bits 8, 9, 10 regulation, inhibit
// R15: abnormal bit 12 trip, 14 overload
// R16: standard event bits 0,2,3,4,5,7 placed
// R17: status bits 4, 5, 6 placed
// R18: enabled events raise service request
// R19: summary is live or of enabled bits
// R20: serial poll returns, clears service bit
// R21: message available while queue not empty
// R22: new event beats same-cycle read clear
module ser_status_event (
  // clock and reset
  input  wire logic        I_CLOCK,
  input  wire logic        I_SYS_RST,
  // normal-operation circuits, asynchronous levels
  input  wire logic        I_CAL_COMPUTING,
  input  wire logic        I_AWAITING_TRIGGER,
  input  wire logic        I_VOLTAGE_REGULATING,
  input  wire logic        I_SECOND_OUTPUT_VOLTAGE_REGULATING,
  input  wire logic        I_POSITIVE_CURRENT_REGULATING,
  input  wire logic        I_SECOND_OUTPUT_CURRENT_REGULATING,
  // abnormal-operation circuits, asynchronous levels
  input  wire logic        I_VOLTAGE_PROTECTION_TRIPPED,
  input  wire logic        I_CURRENT_PROTECTION_TRIPPED,
  input  wire logic        I_PANEL_KEY_PRESSED,
  input  wire logic        I_THERMAL_TRIP_FLAG,
  input  wire logic        I_SENSE_LEAD_OPEN,
  input  wire logic        I_SECOND_OUTPUT_REGULATION_LOST,
  input  wire logic        I_INHIBIT_ACTIVE,
  input  wire logic        I_OUTPUT_REGULATION_LOST,
  input  wire logic        I_SECOND_OUTPUT_CURRENT_TRIP,
  input  wire logic        I_LOW_RANGE_OVERLOAD,
  // standard events, one-cycle pulses
  input  wire logic        I_OP_COMPLETE,
  input  wire logic        I_QUERY_ERROR,
  input  wire logic        I_DEVICE_ERROR,
  input  wire logic        I_EXEC_ERROR,
  input  wire logic        I_COMMAND_ERROR,
  // output queue state
  input  wire logic        I_QUEUE_NOT_EMPTY,
  // command port
  input  wire logic [3:0]  I_REG_SEL,
  input  wire logic        I_REG_WR,
  input  wire logic        I_REG_RD,
  input  wire logic [15:0] I_REG_WDATA,
  output logic      [15:0] O_REG_RDATA,
  output logic             O_REG_RVALID,
  // serial poll
  input  wire logic        I_SERIAL_POLL,
  output logic      [7:0]  O_POLL_DATA,
  output logic             O_POLL_VALID,
  // service request and group summaries
  output logic             O_SRQ,
  output logic             O_MSS,
  output logic             O_ACTIVITY_SUMMARY,
  output logic             O_ABNORMAL_SUMMARY
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ser_pkg::ser_state_t q;       // registered state
  ser_pkg::ser_state_t next_q;  // next state

  logic [15:0] raw_norm;    // normal inputs as a vector
  logic [15:0] raw_abn;     // abnormal inputs as a vector
  logic [7:0]  std_set;     // standard events this cycle
  logic [15:0] norm_new;    // filtered normal transitions
  logic [15:0] abn_new;     // filtered abnormal transitions
  logic [7:0]  stb_base;    // status byte without bit 6
  logic        mss;         // live service summary
  logic        activity_sum;
  logic        abnormal_sum;
  logic        std_sum;
  logic        rd_go;       // read accepted
  logic        wr_go;       // write accepted

  // ----------------------------------------------------------------
  // input vectors
  // ----------------------------------------------------------------

  // gather condition and event inputs into bit positions
  always_comb begin
    raw_norm = 16'h0000;
    raw_abn  = 16'h0000;
    std_set  = 8'h00;
    // R9 calibration, trigger wait
    raw_norm[`SER_N_CAL_COMPUTING]      = I_CAL_COMPUTING;
    raw_norm[`SER_N_AWAITING_TRIGGER]   = I_AWAITING_TRIGGER;
    // R10 voltage regulation bits
    raw_norm[`SER_N_VOLTAGE_REG]        = I_VOLTAGE_REGULATING;
    raw_norm[`SER_N_SECOND_VOLTAGE_REG] =
      I_SECOND_OUTPUT_VOLTAGE_REGULATING;
    // R11 current regulation bits
    raw_norm[`SER_N_POS_CURRENT_REG]    = I_POSITIVE_CURRENT_REGULATING;
    raw_norm[`SER_N_SECOND_CURRENT_REG] =
      I_SECOND_OUTPUT_CURRENT_REGULATING;
    // R12 protection trips
    raw_abn[`SER_A_VOLTAGE_TRIP]        = I_VOLTAGE_PROTECTION_TRIPPED;
    raw_abn[`SER_A_CURRENT_TRIP]        = I_CURRENT_PROTECTION_TRIPPED;
    raw_abn[`SER_A_THERMAL_TRIP]        = I_THERMAL_TRIP_FLAG;
    // R13 panel key, open sense lead
    raw_abn[`SER_A_PANEL_KEY]           = I_PANEL_KEY_PRESSED;
    raw_abn[`SER_A_SENSE_OPEN]          = I_SENSE_LEAD_OPEN;
    // R14 regulation lost, inhibit
    raw_abn[`SER_A_SECOND_REG_LOST]     = I_SECOND_OUTPUT_REGULATION_LOST;
    raw_abn[`SER_A_INHIBIT]             = I_INHIBIT_ACTIVE;
    raw_abn[`SER_A_REG_LOST]            = I_OUTPUT_REGULATION_LOST;
    // R15 second trip, range overload
    raw_abn[`SER_A_SECOND_CURR_TRIP]    = I_SECOND_OUTPUT_CURRENT_TRIP;
    raw_abn[`SER_A_LOW_RANGE_OVLD]      = I_LOW_RANGE_OVERLOAD;
    // R16 standard event positions
    std_set[`SER_E_OP_COMPLETE]         = I_OP_COMPLETE;
    std_set[`SER_E_QUERY_ERROR]         = I_QUERY_ERROR;
    std_set[`SER_E_DEVICE_ERROR]        = I_DEVICE_ERROR;
    std_set[`SER_E_EXEC_ERROR]          = I_EXEC_ERROR;
    std_set[`SER_E_COMMAND_ERROR]       = I_COMMAND_ERROR;
  end

  // ----------------------------------------------------------------
  // summaries
  // ----------------------------------------------------------------

  // transitions and summary bits
  always_comb begin
    // R2 rising edges through filter
    // R3 falling edges through filter
    norm_new = (q.norm_sync & ~q.norm_cond & q.norm_rise)
             | (~q.norm_sync & q.norm_cond & q.norm_fall);
    abn_new  = (q.abn_sync & ~q.abn_cond & q.abn_rise)
             | (~q.abn_sync & q.abn_cond & q.abn_fall);
    // R6 mask gates summaries
    activity_sum = |(q.norm_latch & q.norm_mask);
    abnormal_sum = |(q.abn_latch & q.abn_mask);
    std_sum      = |(q.std_latch & q.std_mask);
    stb_base     = 8'h00;
    // R7 normal summary bit 7
    stb_base[`SER_S_ACTIVITY_SUM] = activity_sum;
    // R8 abnormal summary bit 3
    stb_base[`SER_S_ABNORMAL_SUM] = abnormal_sum;
    // R17 message and standard bits
    // R21 queue not empty
    stb_base[`SER_S_MSG_AVAIL]    = I_QUEUE_NOT_EMPTY;
    stb_base[`SER_S_STD_SUM]      = std_sum;
    // R19 live enabled or
    mss = |(stb_base & q.srq_mask);
  end

  assign rd_go = I_REG_RD;
  assign wr_go = I_REG_WR & ~I_REG_RD;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------

  // one next-state process for the whole block
  always_comb begin
    next_q = q;
    // two-flop synchronisers
    next_q.norm_meta = raw_norm;
    next_q.norm_sync = q.norm_meta;
    next_q.abn_meta  = raw_abn;
    next_q.abn_sync  = q.abn_meta;
    // R1 condition follows circuits
    next_q.norm_cond = q.norm_sync;
    next_q.abn_cond  = q.abn_sync;

    // R4 latches hold, R5 read clears
    // R22 new event beats clear
    next_q.norm_latch = (rd_go && I_REG_SEL == `SER_SEL_NORM_LATCH)
                      ? norm_new : (q.norm_latch | norm_new);
    next_q.abn_latch  = (rd_go && I_REG_SEL == `SER_SEL_ABN_LATCH)
                      ? abn_new : (q.abn_latch | abn_new);
    next_q.std_latch  = (rd_go && I_REG_SEL == `SER_SEL_STD_LATCH)
                      ? std_set : (q.std_latch | std_set);

    // writes to writable registers; others ignored
    if (wr_go) begin
      unique case (I_REG_SEL)
        `SER_SEL_NORM_RISE: next_q.norm_rise = I_REG_WDATA;
        `SER_SEL_NORM_FALL: next_q.norm_fall = I_REG_WDATA;
        `SER_SEL_NORM_MASK: next_q.norm_mask = I_REG_WDATA;
        `SER_SEL_ABN_RISE:  next_q.abn_rise  = I_REG_WDATA;
        `SER_SEL_ABN_FALL:  next_q.abn_fall  = I_REG_WDATA;
        `SER_SEL_ABN_MASK:  next_q.abn_mask  = I_REG_WDATA;
        `SER_SEL_STD_MASK:  next_q.std_mask  = I_REG_WDATA[7:0];
        `SER_SEL_SRQ_MASK:  next_q.srq_mask  = I_REG_WDATA[7:0];
        default: ;
      endcase
    end

    // read answer, registered
    next_q.rd_valid = rd_go;
    next_q.rd_data  = q.rd_data;
    if (rd_go) begin
      unique case (I_REG_SEL)
        `SER_SEL_NORM_COND:   next_q.rd_data = q.norm_cond;
        `SER_SEL_NORM_RISE:   next_q.rd_data = q.norm_rise;
        `SER_SEL_NORM_FALL:   next_q.rd_data = q.norm_fall;
        `SER_SEL_NORM_LATCH:  next_q.rd_data = q.norm_latch;
        `SER_SEL_NORM_MASK:   next_q.rd_data = q.norm_mask;
        `SER_SEL_ABN_COND:    next_q.rd_data = q.abn_cond;
        `SER_SEL_ABN_RISE:    next_q.rd_data = q.abn_rise;
        `SER_SEL_ABN_FALL:    next_q.rd_data = q.abn_fall;
        `SER_SEL_ABN_LATCH:   next_q.rd_data = q.abn_latch;
        `SER_SEL_ABN_MASK:    next_q.rd_data = q.abn_mask;
        `SER_SEL_STD_LATCH:   next_q.rd_data = {8'h00, q.std_latch};
        `SER_SEL_STD_MASK:    next_q.rd_data = {8'h00, q.std_mask};
        `SER_SEL_SRQ_MASK:    next_q.rd_data = {8'h00, q.srq_mask};
        // status byte read shows live summary, clears nothing
        `SER_SEL_STATUS_BYTE: next_q.rd_data =
          {8'h00, stb_base[7], mss, stb_base[5:0]};
        default:              next_q.rd_data = 16'h0000;
      endcase
    end

    // R18 rising summary requests service
    next_q.mss_prev = mss;
    // R20 poll returns, clears only service bit
    next_q.poll_valid = I_SERIAL_POLL;
    if (I_SERIAL_POLL) begin
      next_q.poll_data = {stb_base[7], q.rqs, stb_base[5:0]};
    end
    if (mss && !q.mss_prev) begin
      next_q.rqs = 1'b1;
    end else if (I_SERIAL_POLL) begin
      next_q.rqs = 1'b0;
    end

    // synchronous reset to power-on values
    if (I_SYS_RST) begin
      next_q            = '0;
      next_q.norm_rise  = `SER_RST_RISE;
      next_q.norm_fall  = `SER_RST_FALL;
      next_q.norm_mask  = `SER_RST_MASK16;
      next_q.abn_rise   = `SER_RST_RISE;
      next_q.abn_fall   = `SER_RST_FALL;
      next_q.abn_mask   = `SER_RST_MASK16;
      next_q.std_mask   = `SER_RST_MASK8;
      next_q.srq_mask   = `SER_RST_MASK8;
      // R16 power-on event latched
      next_q.std_latch  = `SER_RST_STD_LATCH;
    end
  end

  // ----------------------------------------------------------------
  // register and outputs
  // ----------------------------------------------------------------

  // single state register
  always_ff @(posedge I_CLOCK) begin
    q <= next_q;
  end

  assign O_REG_RDATA        = q.rd_data;
  assign O_REG_RVALID       = q.rd_valid;
  assign O_POLL_DATA        = q.poll_data;
  assign O_POLL_VALID       = q.poll_valid;
  assign O_SRQ              = q.rqs;
  assign O_MSS              = mss;
  assign O_ACTIVITY_SUMMARY = activity_sum;
  assign O_ABNORMAL_SUMMARY = abnormal_sum;

endmodule : ser_status_event

`default_nettype wire

// file: ser_status_event_regs.svh
/*
  register selects, bit positions, reset values for the status
  event reporting block. assumes inclusion by bare name.
*/
`ifndef SER_STATUS_EVENT_REGS_SVH
`define SER_STATUS_EVENT_REGS_SVH

// ----------------------------------------------------------------
// register selects on the command port
// ----------------------------------------------------------------
`define SER_SEL_NORM_COND   4'h0
`define SER_SEL_NORM_RISE   4'h1
`define SER_SEL_NORM_FALL   4'h2
`define SER_SEL_NORM_LATCH  4'h3
`define SER_SEL_NORM_MASK   4'h4
`define SER_SEL_ABN_COND    4'h5
`define SER_SEL_ABN_RISE    4'h6
`define SER_SEL_ABN_FALL    4'h7
`define SER_SEL_ABN_LATCH   4'h8
`define SER_SEL_ABN_MASK    4'h9
`define SER_SEL_STD_LATCH   4'hA
`define SER_SEL_STD_MASK    4'hB
`define SER_SEL_STATUS_BYTE 4'hC
`define SER_SEL_SRQ_MASK    4'hD

// ----------------------------------------------------------------
// normal-operation condition bit positions
// ----------------------------------------------------------------
`define SER_N_CAL_COMPUTING      0
`define SER_N_AWAITING_TRIGGER   5
`define SER_N_VOLTAGE_REG        8
`define SER_N_SECOND_VOLTAGE_REG 9
`define SER_N_POS_CURRENT_REG    10
`define SER_N_SECOND_CURRENT_REG 12

// ----------------------------------------------------------------
// abnormal-operation condition bit positions
// ----------------------------------------------------------------
`define SER_A_VOLTAGE_TRIP       0
`define SER_A_CURRENT_TRIP       1
`define SER_A_PANEL_KEY          3
`define SER_A_THERMAL_TRIP       4
`define SER_A_SENSE_OPEN         5
`define SER_A_SECOND_REG_LOST    8
`define SER_A_INHIBIT            9
`define SER_A_REG_LOST           10
`define SER_A_SECOND_CURR_TRIP   12
`define SER_A_LOW_RANGE_OVLD     14

// ----------------------------------------------------------------
// standard event bit positions
// ----------------------------------------------------------------
`define SER_E_OP_COMPLETE   0
`define SER_E_QUERY_ERROR   2
`define SER_E_DEVICE_ERROR  3
`define SER_E_EXEC_ERROR    4
`define SER_E_COMMAND_ERROR 5
`define SER_E_POWER_ON      7

// ----------------------------------------------------------------
// status byte bit positions
// ----------------------------------------------------------------
`define SER_S_ABNORMAL_SUM  3
`define SER_S_MSG_AVAIL     4
`define SER_S_STD_SUM       5
`define SER_S_SERVICE       6
`define SER_S_ACTIVITY_SUM  7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SER_RST_RISE        16'hFFFF
`define SER_RST_FALL        16'h0000
`define SER_RST_MASK16      16'h0000
`define SER_RST_MASK8       8'h00
`define SER_RST_STD_LATCH   8'h80

`endif

// file: ser_pkg.sv
/*
  types of the status event reporting block.
  assumes ser_status_event_regs.svh is compiled alongside.
*/
`default_nettype none

package ser_pkg;

  // whole state of the block, registered once per clock
  typedef struct packed {
    logic [15:0] norm_meta;   // first sync stage, normal group
    logic [15:0] norm_sync;   // second sync stage
    logic [15:0] norm_cond;   // condition register
    logic [15:0] norm_rise;   // rising filter
    logic [15:0] norm_fall;   // falling filter
    logic [15:0] norm_latch;  // event latch
    logic [15:0] norm_mask;   // event mask
    logic [15:0] abn_meta;
    logic [15:0] abn_sync;
    logic [15:0] abn_cond;
    logic [15:0] abn_rise;
    logic [15:0] abn_fall;
    logic [15:0] abn_latch;
    logic [15:0] abn_mask;
    logic [7:0]  std_latch;   // standard event latch
    logic [7:0]  std_mask;    // standard event mask
    logic [7:0]  srq_mask;    // service request mask
    logic        rqs;         // latched service request
    logic        mss_prev;    // summary one cycle ago
    logic [15:0] rd_data;     // read answer
    logic        rd_valid;    // read answer strobe
    logic [7:0]  poll_data;   // serial poll answer
    logic        poll_valid;  // serial poll strobe
  } ser_state_t;

endpackage : ser_pkg

`default_nettype wire

// file: ser_gpib_ctrl.sv
/*
  gpib controller model: register reads, writes, serial poll.
  assumes the status block's command port on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ser_gpib_ctrl (
  // clock
  input  wire logic        i_clock,
  // answers from the device
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_rvalid,
  input  wire logic [7:0]  i_poll_data,
  input  wire logic        i_poll_valid,
  // requests to the device
  output var  logic [3:0]  o_sel,
  output var  logic        o_wr,
  output var  logic        o_rd,
  output var  logic [15:0] o_wdata,
  output var  logic        o_poll
);
  // idle bus at time zero
  initial begin
    o_sel   = 4'h0;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 16'h0000;
    o_poll  = 1'b0;
  end

  // one write; data line scrambled once released
  task automatic wr_reg(input logic [3:0] s, input logic [15:0] d);
    @(negedge i_clock);
    o_sel   = s;
    o_wdata = d;
    o_wr    = 1'b1;
    @(negedge i_clock);
    o_wr    = 1'b0;
    o_wdata = ~d;
  endtask : wr_reg

  // one read; answer taken only with its strobe
  task automatic rd_reg(input logic [3:0] s, output logic [15:0] d);
    @(negedge i_clock);
    o_sel = s;
    o_rd  = 1'b1;
    @(negedge i_clock);
    o_rd  = 1'b0;
    d     = (i_rvalid === 1'b1) ? i_rdata : 16'hXXXX;
  endtask : rd_reg

  task automatic poll_dev(output logic [7:0] d);
    @(negedge i_clock);
    o_poll = 1'b1;
    @(negedge i_clock);
    o_poll = 1'b0;
    d      = (i_poll_valid === 1'b1) ? i_poll_data : 8'hXX;
  endtask : poll_dev
endmodule : ser_gpib_ctrl
`default_nettype wire

// file: ser_status_event_asserts.sv
/*
  checker for the status event block, top ports only.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ser_status_event_asserts (
  // clock and reset
  input wire logic        I_CLOCK,
  input wire logic        I_SYS_RST,
  // requests
  input wire logic        I_QUEUE_NOT_EMPTY,
  input wire logic [3:0]  I_REG_SEL,
  input wire logic        I_REG_WR,
  input wire logic        I_REG_RD,
  input wire logic        I_SERIAL_POLL,
  // answers
  input wire logic [15:0] O_REG_RDATA,
  input wire logic        O_REG_RVALID,
  input wire logic [7:0]  O_POLL_DATA,
  input wire logic        O_POLL_VALID,
  input wire logic        O_SRQ,
  input wire logic        O_MSS,
  input wire logic        O_ACTIVITY_SUMMARY,
  input wire logic        O_ABNORMAL_SUMMARY
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);

  property p_read_strobe;
    I_REG_RD |=> O_REG_RVALID;
  endproperty
  a_read_strobe: assert property (p_read_strobe)
    else $error("no read answer");
  property p_read_quiet;
    !I_REG_RD |=> !O_REG_RVALID;
  endproperty
  a_read_quiet: assert property (p_read_quiet)
    else $error("stray answer");
  property p_poll_answer;
    I_SERIAL_POLL |=> O_POLL_VALID
      && O_POLL_DATA[7] == $past(O_ACTIVITY_SUMMARY)
      && O_POLL_DATA[6] == $past(O_SRQ)
      && O_POLL_DATA[3] == $past(O_ABNORMAL_SUMMARY);
  endproperty
  a_poll_answer: assert property (p_poll_answer)
    else $error("poll answer");
  property p_stb_read;
    I_REG_RD && I_REG_SEL == 4'hC |=> O_REG_RDATA[15:8] == 8'h00
      && O_REG_RDATA[7] == $past(O_ACTIVITY_SUMMARY)
      && O_REG_RDATA[6] == $past(O_MSS)
      && O_REG_RDATA[4] == $past(I_QUEUE_NOT_EMPTY)
      && O_REG_RDATA[3] == $past(O_ABNORMAL_SUMMARY);
  endproperty
  a_stb_read: assert property (p_stb_read)
    else $error("status byte");
  property p_srq_set;
    $rose(O_MSS) |=> O_SRQ;
  endproperty
  a_srq_set: assert property (p_srq_set)
    else $error("no request");
  property p_srq_clear;
    I_SERIAL_POLL && !$rose(O_MSS) |=> !O_SRQ;
  endproperty
  a_srq_clear: assert property (p_srq_clear)
    else $error("poll no clear");
  property p_srq_hold;
    !I_SERIAL_POLL && !$rose(O_MSS) |=> $stable(O_SRQ);
  endproperty
  a_srq_hold: assert property (p_srq_hold)
    else $error("request moved");
  property p_act_hold;
    O_ACTIVITY_SUMMARY && !(I_REG_RD && I_REG_SEL == 4'h3)
      && !(I_REG_WR && I_REG_SEL == 4'h4) |=> O_ACTIVITY_SUMMARY;
  endproperty
  a_act_hold: assert property (p_act_hold)
    else $error("normal lost");
  property p_abn_hold;
    O_ABNORMAL_SUMMARY && !(I_REG_RD && I_REG_SEL == 4'h8)
      && !(I_REG_WR && I_REG_SEL == 4'h9) |=> O_ABNORMAL_SUMMARY;
  endproperty
  a_abn_hold: assert property (p_abn_hold)
    else $error("abnormal lost");

  // main scenarios reached
  c_srq: cover property ($rose(O_SRQ));
  c_poll: cover property (I_SERIAL_POLL && O_SRQ);
  c_clear: cover property (O_ACTIVITY_SUMMARY && I_REG_RD
    && I_REG_SEL == 4'h3);
endmodule : ser_status_event_asserts

bind ser_status_event ser_status_event_asserts u_ser_status_event_asserts (
  .I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST),
  .I_QUEUE_NOT_EMPTY(I_QUEUE_NOT_EMPTY), .I_REG_SEL(I_REG_SEL),
  .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .I_SERIAL_POLL(I_SERIAL_POLL),
  .O_REG_RDATA(O_REG_RDATA), .O_REG_RVALID(O_REG_RVALID),
  .O_POLL_DATA(O_POLL_DATA), .O_POLL_VALID(O_POLL_VALID), .O_SRQ(O_SRQ),
  .O_MSS(O_MSS), .O_ACTIVITY_SUMMARY(O_ACTIVITY_SUMMARY),
  .O_ABNORMAL_SUMMARY(O_ABNORMAL_SUMMARY));
`default_nettype wire

// file: tb_status_event_reporting.sv
/*
  self-checking bench for the status event block.
  assumes the controller model and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_status_event_reporting;
  logic        clk, rst, queue;
  logic [5:0]  nin;
  logic [9:0]  ain;
  logic [4:0]  std;
  logic [3:0]  sel;
  logic        wr, rd, poll, rvalid, pvalid, srq, mss, act, abn;
  logic [15:0] wdata, rdata, d, e;
  logic [7:0]  pdata, b;
  int          n_errors, comparisons, i, p;
  // expected reset values by select; writable selects
  localparam logic [15:0] RST_EXP [16] = '{16'h0000, 16'hFFFF, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000,
    16'h0080, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] WR_SET = 16'h2AD6;
  localparam int POS [16] = '{0, 5, 8, 9, 10, 12, 0, 1, 3, 4, 5, 8, 9, 10,
    12, 14};

  // 200 MHz clock
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  ser_status_event u_ser_status_event (
    .I_CLOCK(clk), .I_SYS_RST(rst), .I_CAL_COMPUTING(nin[0]),
    .I_AWAITING_TRIGGER(nin[1]), .I_VOLTAGE_REGULATING(nin[2]),
    .I_SECOND_OUTPUT_VOLTAGE_REGULATING(nin[3]),
    .I_POSITIVE_CURRENT_REGULATING(nin[4]),
    .I_SECOND_OUTPUT_CURRENT_REGULATING(nin[5]),
    .I_VOLTAGE_PROTECTION_TRIPPED(ain[0]),
    .I_CURRENT_PROTECTION_TRIPPED(ain[1]), .I_PANEL_KEY_PRESSED(ain[2]),
    .I_THERMAL_TRIP_FLAG(ain[3]), .I_SENSE_LEAD_OPEN(ain[4]),
    .I_SECOND_OUTPUT_REGULATION_LOST(ain[5]), .I_INHIBIT_ACTIVE(ain[6]),
    .I_OUTPUT_REGULATION_LOST(ain[7]), .I_SECOND_OUTPUT_CURRENT_TRIP(ain[8]),
    .I_LOW_RANGE_OVERLOAD(ain[9]), .I_OP_COMPLETE(std[0]),
    .I_QUERY_ERROR(std[1]), .I_DEVICE_ERROR(std[2]), .I_EXEC_ERROR(std[3]),
    .I_COMMAND_ERROR(std[4]), .I_QUEUE_NOT_EMPTY(queue), .I_REG_SEL(sel),
    .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
    .O_REG_RVALID(rvalid), .I_SERIAL_POLL(poll), .O_POLL_DATA(pdata),
    .O_POLL_VALID(pvalid), .O_SRQ(srq), .O_MSS(mss),
    .O_ACTIVITY_SUMMARY(act), .O_ABNORMAL_SUMMARY(abn));

  ser_gpib_ctrl u_ser_gpib_ctrl (
    .i_clock(clk), .i_rdata(rdata), .i_rvalid(rvalid), .i_poll_data(pdata),
    .i_poll_valid(pvalid), .o_sel(sel), .o_wr(wr), .o_rd(rd),
    .o_wdata(wdata), .o_poll(poll));

  // ----------------------------------------------------------------
  // compare and closing tasks
  // ----------------------------------------------------------------
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  task automatic stop_test();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // sync plus latch pipeline has passed
  task automatic settle();
    repeat (6) @(negedge clk);
  endtask : settle

  // hang guard, far above the expected run
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    queue = 1'b0;
    nin = 6'h00;
    ain = 10'h000;
    std = 5'h00;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    // reset values; power-on bit gone after its read
    for (i = 0; i < 16; i++) begin
      u_ser_gpib_ctrl.rd_reg(i[3:0], d);
      chk16(d, RST_EXP[i]);
    end
    u_ser_gpib_ctrl.rd_reg(4'hA, d);
    chk16(d, 16'h0000);
    // write everywhere, only writable places keep it
    for (i = 0; i < 16; i++) u_ser_gpib_ctrl.wr_reg(i[3:0], 16'h5AB5);
    for (i = 0; i < 16; i++) begin
      u_ser_gpib_ctrl.rd_reg(i[3:0], d);
      e = !WR_SET[i] ? ((i == 10) ? 16'h0000 : RST_EXP[i])
        : ((i > 10) ? 16'h00B5 : 16'h5AB5);
      chk16(d, e);
    end
    for (i = 0; i < 16; i++)
      if (WR_SET[i]) u_ser_gpib_ctrl.wr_reg(i[3:0], RST_EXP[i]);
    // each circuit to its condition and event bit
    for (i = 0; i < 16; i++) begin
      p = POS[i];
      {ain, nin} = 16'h0001 << i;
      settle();
      u_ser_gpib_ctrl.rd_reg((i > 5) ? 4'h5 : 4'h0, d);
      chk16(d, 16'h0001 << p);
      u_ser_gpib_ctrl.rd_reg((i > 5) ? 4'h8 : 4'h3, d);
      chk16(d, 16'h0001 << p);
      {ain, nin} = 16'h0000;
      settle();
      u_ser_gpib_ctrl.rd_reg((i > 5) ? 4'h8 : 4'h3, d);
      chk16(d, 16'h0000);
    end
    // falling-edge event through mask to service request
    u_ser_gpib_ctrl.wr_reg(4'h1, 16'h0000);
    u_ser_gpib_ctrl.wr_reg(4'h2, 16'h0400);
    u_ser_gpib_ctrl.wr_reg(4'h4, 16'h0400);
    u_ser_gpib_ctrl.wr_reg(4'hD, 16'h0080);
    nin[4] = 1'b1;
    settle();
    u_ser_gpib_ctrl.rd_reg(4'h3, d);
    chk16(d, 16'h0000);
    chk1(act, 1'b0);
    nin[4] = 1'b0;
    settle();
    chk1(act, 1'b1);
    chk1(mss, 1'b1);
    chk1(srq, 1'b1);
    u_ser_gpib_ctrl.poll_dev(b);
    chk16({8'h00, b}, 16'h00C0);
    chk1(srq, 1'b0);
    u_ser_gpib_ctrl.rd_reg(4'hC, d);
    chk16(d, 16'h00C0);
    queue = 1'b1;
    u_ser_gpib_ctrl.rd_reg(4'hC, d);
    chk16(d, 16'h00D0);
    nin[4] = 1'b1;
    settle();
    u_ser_gpib_ctrl.rd_reg(4'h3, d);
    chk16(d, 16'h0400);
    u_ser_gpib_ctrl.rd_reg(4'h3, d);
    chk16(d, 16'h0000);
    chk1(mss, 1'b0);
    // abnormal summary on status bit 3
    u_ser_gpib_ctrl.wr_reg(4'h9, 16'h0001);
    ain[0] = 1'b1;
    settle();
    chk1(abn, 1'b1);
    u_ser_gpib_ctrl.rd_reg(4'hC, d);
    chk16(d, 16'h0018);
    u_ser_gpib_ctrl.rd_reg(4'h8, d);
    chk16(d, 16'h0001);
    chk1(abn, 1'b0);
    // standard events and their summary
    u_ser_gpib_ctrl.wr_reg(4'hB, 16'h0001);
    @(negedge clk);
    std = 5'h1F;
    @(negedge clk);
    std = 5'h00;
    u_ser_gpib_ctrl.rd_reg(4'hC, d);
    chk16(d, 16'h0030);
    u_ser_gpib_ctrl.rd_reg(4'hA, d);
    chk16(d, 16'h003D);
    u_ser_gpib_ctrl.rd_reg(4'hC, d);
    chk16(d, 16'h0010);
    // event in the very read cycle survives the clear
    fork
      u_ser_gpib_ctrl.rd_reg(4'hA, d);
      begin
        @(negedge clk);
        std = 5'h01;
        @(negedge clk);
        std = 5'h00;
      end
    join
    chk16(d, 16'h0000);
    u_ser_gpib_ctrl.rd_reg(4'hA, d);
    chk16(d, 16'h0001);
    stop_test();
  end
endmodule : tb_status_event_reporting
`default_nettype wire
